//--- common/mmp_regs.vh
// Constants for the memory map and nonvolatile protection block
`ifndef MMP_REGS_VH
`define MMP_REGS_VH

// ----------------------------------------------------------------
// APB register offsets (byte addresses)
// ----------------------------------------------------------------
`define MMP_OFS_CTRL     8'h00
`define MMP_OFS_STATUS   8'h04
`define MMP_OFS_LOCK     8'h08
`define MMP_OFS_FUSE     8'h0C
`define MMP_OFS_INDEX    8'h10
`define MMP_OFS_SIGDATA  8'h14
`define MMP_OFS_USIGCMD  8'h18
`define MMP_OFS_EEBUF    8'h1C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MMP_CTRL_EEMAP   0
`define MMP_ST_SPMREF    0
`define MMP_ST_LOCKREF   1
`define MMP_ST_SIGREF    2
`define MMP_ST_FUSEREF   3
`define MMP_ST_ERASING   4
`define MMP_ST_CALDONE   5
`define MMP_ST_W         6
`define MMP_LOCK_RST     8'hFF
`define MMP_FUSE_RST     8'hFF

// ----------------------------------------------------------------
// Data space map (byte addresses)
// ----------------------------------------------------------------
`define MMP_IO_END       16'h0FFF
`define MMP_EE_BASE      16'h1000
`define MMP_EE_END       16'h17FF
`define MMP_SRAM_BASE    16'h2000
`define MMP_SRAM_END     16'h3FFF

// ----------------------------------------------------------------
// Flash map (word addresses, 16-bit words)
// ----------------------------------------------------------------
`define MMP_ATAB_BASE    17'h0F000
`define MMP_BOOT_BASE    17'h10000
`define MMP_FLASH_END    17'h10FFF

// ----------------------------------------------------------------
// Section codes, programmer operations, timing
// ----------------------------------------------------------------
`define MMP_SEC_APP      2'd0
`define MMP_SEC_ATAB     2'd1
`define MMP_SEC_BOOT     2'd2
`define MMP_SEC_NONE     2'd3
`define MMP_POP_LOCK     2'd0
`define MMP_POP_FUSE     2'd1
`define MMP_POP_CHIPER   2'd2
`define MMP_POP_SIGWR    2'd3
`define MMP_ERASE_CYC    8'd16
`define MMP_SIG_IDX_OSC  5'd7
`define MMP_SIG_IDX_ADC  5'd8

`endif

//--- hw/mmp_lock_ctl.v
// Lock bits, fuses and chip erase sequencer
`timescale 1ns/100ps
`include "mmp_regs.vh"

module mmp_lock_ctl (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Software lock write
  input  wire       sw_lock_wr,
  input  wire [7:0] sw_lock_data,
  // Programmer port
  input  wire       prog_valid,
  input  wire [1:0] prog_op,
  input  wire [7:0] prog_data,
  // Results
  output reg  [7:0] lock_q,
  output reg  [7:0] fuse_q,
  output reg        lock_refused_q,
  output reg        erase_busy_q,
  output reg        flash_erase_q
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_FLASH = 2'd1;
  localparam ST_LOCKS = 2'd2;

  reg [1:0] state_q;
  reg [7:0] cnt_q;
  wire      prog_lock = prog_valid && (prog_op == `MMP_POP_LOCK);
  wire      any_wr    = sw_lock_wr || prog_lock;
  // Programmer wins when both write in the same cycle
  wire [7:0] wr_data  = prog_lock ? prog_data : sw_lock_data;
  // Loosening means turning a programmed zero back into one
  wire      loosen    = |(wr_data & ~lock_q);

  // ----------------------------------------------------------------
  // Lock, fuse and erase sequencing
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q         <= `MMP_LOCK_RST;
      fuse_q         <= `MMP_FUSE_RST;
      lock_refused_q <= 1'b0;
      erase_busy_q   <= 1'b0;
      flash_erase_q  <= 1'b0;
      state_q        <= ST_IDLE;
      cnt_q          <= 8'h00;
    end else begin
      lock_refused_q <= 1'b0;
      flash_erase_q  <= 1'b0;
      // Whole write is refused, never merged partially
      if (any_wr && state_q == ST_IDLE) begin
        if (loosen)
          lock_refused_q <= 1'b1;
        else
          lock_q <= wr_data;
      end
      // Fuses change only from the programmer port
      if (prog_valid && prog_op == `MMP_POP_FUSE)
        fuse_q <= prog_data;
      case (state_q)
        ST_IDLE: begin
          if (prog_valid && prog_op == `MMP_POP_CHIPER) begin
            state_q       <= ST_FLASH;
            erase_busy_q  <= 1'b1;
            flash_erase_q <= 1'b1;
            cnt_q         <= `MMP_ERASE_CYC;
          end
        end
        ST_FLASH: begin
          cnt_q <= cnt_q - 8'd1;
          if (cnt_q == 8'd1)
            state_q <= ST_LOCKS;
        end
        ST_LOCKS: begin
          // Locks open only once the flash is gone
          lock_q       <= `MMP_LOCK_RST;
          erase_busy_q <= 1'b0;
          state_q      <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

//--- hw/mmp_top.v
// Data space decoder, flash self-write gate and nonvolatile access policy
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "mmp_regs.vh"

// Summary of operation
// - I/O decodes 0 to FFF, SRAM from 2000 on every size
// - Mapped EEPROM spans 1000 to 17FF; above it reserved up to SRAM
// - EEPROM stays in its own space unless mapping is enabled
// - Byte and page EEPROM access; mapped stores fill the page buffer
// - Flash is 16-bit words addressed by word; instructions use one or two
// - Self-write runs only when fetched from boot; else it is dropped and the refusal flagged in status
// - Permitted self-write may target all flash, boot included
// - Application table F000 (large) below boot at 10000, same size as boot
// - Lock bits change only towards stricter; loosening writes are refused
// - Only chip erase clears locks, after all other flash is erased
// - Unprogrammed fuse or lock reads one, programmed reads zero
// - Fuses written only by the programmer; software reads them
// - Factory signature row readable, every write or erase rejected
// - Selected calibration values copied from signature row at reset
// - Three device id bytes plus serial from lot, wafer, coordinates
// - User row has its own erase command; chip erase spares it
// - EEPROM byte index is address 4:0, page from upper bits
// - I/O and SRAM writes take one cycle; SRAM read takes two
module mmp_top #(
  parameter [7:0] DEV_ID0  = 8'hA5, // Arbitrary identity value
  parameter [7:0] DEV_ID1  = 8'h5A, // Arbitrary identity value
  parameter [7:0] DEV_ID2  = 8'h3C, // Arbitrary identity value
  parameter [7:0] LOT_NUM  = 8'h11,
  parameter [7:0] WAFER    = 8'h02,
  parameter [7:0] COORD_X  = 8'h03,
  parameter [7:0] COORD_Y  = 8'h04,
  parameter [7:0] CAL_OSC  = 8'h40,
  parameter [7:0] CAL_ADC  = 8'h20
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // CPU data access
  input  wire        cpu_req,
  input  wire        cpu_we,
  input  wire [15:0] cpu_addr,
  input  wire [7:0]  cpu_wdata,
  output reg         sel_io_q,
  output reg         sel_ee_q,
  output reg         sel_sram_q,
  output reg         sel_rsvd_q,
  output reg         cpu_done_q,
  output reg  [5:0]  eeprom_page_index_q,
  output reg  [4:0]  eeprom_byte_index_q,
  // Flash self-write instruction
  input  wire        spm_req,
  input  wire [16:0] spm_pc,
  input  wire [16:0] spm_addr,
  input  wire [15:0] spm_wdata,
  output reg         flash_wr_q,
  output reg  [16:0] flash_addr_q,
  output reg  [15:0] flash_wdata_q,
  // Program debug port
  input  wire        prog_valid,
  input  wire [1:0]  prog_op,
  input  wire [7:0]  prog_data,
  // Memory erase strobes
  output reg         flash_erase_q,
  output reg         usig_erase_q,
  // Calibration targets
  output reg  [7:0]  cal_osc_q,
  output reg  [7:0]  cal_adc_q,
  output reg         cal_done_q
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Flash section of a word address
  function [1:0] flash_sec;
    input [16:0] a;
    begin
      if (a > `MMP_FLASH_END)
        flash_sec = `MMP_SEC_NONE;
      else if (a >= `MMP_BOOT_BASE)
        flash_sec = `MMP_SEC_BOOT;
      else if (a >= `MMP_ATAB_BASE)
        flash_sec = `MMP_SEC_ATAB;
      else
        flash_sec = `MMP_SEC_APP;
    end
  endfunction

  // Factory signature row contents
  function [7:0] sig_byte;
    input [4:0] i;
    begin
      case (i)
        5'd0:             sig_byte = DEV_ID0;
        5'd1:             sig_byte = DEV_ID1;
        5'd2:             sig_byte = DEV_ID2;
        5'd3:             sig_byte = LOT_NUM;
        5'd4:             sig_byte = WAFER;
        5'd5:             sig_byte = COORD_X;
        5'd6:             sig_byte = COORD_Y;
        `MMP_SIG_IDX_OSC: sig_byte = CAL_OSC;
        `MMP_SIG_IDX_ADC: sig_byte = CAL_ADC;
        default:          sig_byte = 8'hFF;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg                 eemap_q;
  reg [`MMP_ST_W-1:0] status_q;
  reg [4:0]           index_q;
  reg                 sram_rd_q;
  reg [1:0]           cal_step_q;
  reg [7:0]           ee_buf [0:31];

  wire [7:0] lock_w;
  wire [7:0] fuse_w;
  wire       lock_ref_w;
  wire       erase_busy_w;
  wire       ce_flash_w;

  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && penable && !pwrite;
  wire [`MMP_ST_W-1:0] st_clr = (apb_wr && paddr == `MMP_OFS_STATUS) ?
                                pwdata[`MMP_ST_W-1:0] : {`MMP_ST_W{1'b0}};

  // ----------------------------------------------------------------
  // Data space decode
  // ----------------------------------------------------------------
  wire in_io   = cpu_addr <= `MMP_IO_END;
  wire in_eewn = cpu_addr >= `MMP_EE_BASE && cpu_addr <= `MMP_EE_END;
  wire in_ee   = in_eewn && eemap_q;
  wire in_sram = cpu_addr >= `MMP_SRAM_BASE && cpu_addr <= `MMP_SRAM_END;
  wire sram_rd = cpu_req && in_sram && !cpu_we;

  // Access strobes and completion timing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_io_q            <= 1'b0;
      sel_ee_q            <= 1'b0;
      sel_sram_q          <= 1'b0;
      sel_rsvd_q          <= 1'b0;
      cpu_done_q          <= 1'b0;
      sram_rd_q           <= 1'b0;
      eeprom_page_index_q <= 6'h00;
      eeprom_byte_index_q <= 5'h00;
    end else begin
      sel_io_q   <= cpu_req && in_io;
      sel_ee_q   <= cpu_req && in_ee;
      sel_sram_q <= cpu_req && in_sram;
      sel_rsvd_q <= cpu_req && !in_io && !in_ee && !in_sram;
      // SRAM read holds one extra cycle before completing
      sram_rd_q  <= sram_rd;
      cpu_done_q <= (cpu_req && !sram_rd) || sram_rd_q;
      if (cpu_req && in_ee) begin
        eeprom_byte_index_q <= cpu_addr[4:0];
        eeprom_page_index_q <= cpu_addr[10:5];
      end
    end
  end

  // Mapped stores land in the page buffer, not the array itself
  always @(posedge pclk) begin
    if (cpu_req && cpu_we && in_ee)
      ee_buf[cpu_addr[4:0]] <= cpu_wdata;
  end

  // ----------------------------------------------------------------
  // Flash self-write gate
  // ----------------------------------------------------------------
  wire [1:0] tgt_sec  = flash_sec(spm_addr);
  wire       from_boot = flash_sec(spm_pc) == `MMP_SEC_BOOT;
  reg        tgt_open;
  // Write is barred unless the section's lock pair is unprogrammed
  always @* begin
    case (tgt_sec)
      `MMP_SEC_APP:  tgt_open = &lock_w[1:0];
      `MMP_SEC_ATAB: tgt_open = &lock_w[3:2];
      `MMP_SEC_BOOT: tgt_open = &lock_w[5:4];
      default:       tgt_open = 1'b0;
    endcase
  end
  wire spm_ok = spm_req && from_boot && tgt_open && !erase_busy_w;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wr_q    <= 1'b0;
      flash_addr_q  <= 17'h00000;
      flash_wdata_q <= 16'h0000;
    end else begin
      flash_wr_q <= spm_ok;
      // Address and data only move on a granted write
      if (spm_ok) begin
        flash_addr_q  <= spm_addr;
        flash_wdata_q <= spm_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock bits, fuses, chip erase
  // ----------------------------------------------------------------
  mmp_lock_ctl u_lock (
    .pclk           (pclk),
    .presetn        (presetn),
    .sw_lock_wr     (apb_wr && paddr == `MMP_OFS_LOCK),
    .sw_lock_data   (pwdata[7:0]),
    .prog_valid     (prog_valid),
    .prog_op        (prog_op),
    .prog_data      (prog_data),
    .lock_q         (lock_w),
    .fuse_q         (fuse_w),
    .lock_refused_q (lock_ref_w),
    .erase_busy_q   (erase_busy_w),
    .flash_erase_q  (ce_flash_w)
  );

  // ----------------------------------------------------------------
  // Control, status, erase strobes, calibration load
  // ----------------------------------------------------------------
  wire sig_wr_ref  = (apb_wr && paddr == `MMP_OFS_SIGDATA) ||
                     (prog_valid && prog_op == `MMP_POP_SIGWR);
  wire fuse_wr_ref = apb_wr && paddr == `MMP_OFS_FUSE;
  wire [`MMP_ST_W-1:0] st_set;
  assign st_set[`MMP_ST_SPMREF]  = spm_req && !spm_ok;
  assign st_set[`MMP_ST_LOCKREF] = lock_ref_w;
  assign st_set[`MMP_ST_SIGREF]  = sig_wr_ref;
  assign st_set[`MMP_ST_FUSEREF] = fuse_wr_ref;
  assign st_set[`MMP_ST_ERASING] = 1'b0;
  assign st_set[`MMP_ST_CALDONE] = 1'b0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eemap_q       <= 1'b0;
      status_q      <= {`MMP_ST_W{1'b0}};
      index_q       <= 5'h00;
      flash_erase_q <= 1'b0;
      usig_erase_q  <= 1'b0;
      cal_osc_q     <= 8'h00;
      cal_adc_q     <= 8'h00;
      cal_done_q    <= 1'b0;
      cal_step_q    <= 2'd0;
    end else begin
      if (apb_wr && paddr == `MMP_OFS_CTRL)
        eemap_q <= pwdata[`MMP_CTRL_EEMAP];
      if (apb_wr && paddr == `MMP_OFS_INDEX)
        index_q <= pwdata[4:0];
      // Sticky flags: a new event beats a same-cycle clear
      status_q <= (status_q & ~st_clr) | st_set;
      status_q[`MMP_ST_ERASING] <= erase_busy_w;
      status_q[`MMP_ST_CALDONE] <= cal_done_q;
      // Chip erase touches flash only, never the user row
      flash_erase_q <= ce_flash_w;
      usig_erase_q  <= apb_wr && paddr == `MMP_OFS_USIGCMD &&
                       pwdata[0] && !erase_busy_w;
      // Auto-load runs in the first cycles after reset release
      case (cal_step_q)
        2'd0: begin
          cal_osc_q  <= sig_byte(`MMP_SIG_IDX_OSC);
          cal_step_q <= 2'd1;
        end
        2'd1: begin
          cal_adc_q  <= sig_byte(`MMP_SIG_IDX_ADC);
          cal_step_q <= 2'd2;
        end
        2'd2: begin
          cal_done_q <= 1'b1;
          cal_step_q <= 2'd3;
        end
        default: cal_step_q <= 2'd3;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read mux and response, zero wait states
  // ----------------------------------------------------------------
  reg [31:0] rd_d;
  reg        err_d;
  always @* begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (paddr)
      `MMP_OFS_CTRL:    rd_d[0] = eemap_q;
      `MMP_OFS_STATUS:  rd_d[`MMP_ST_W-1:0] = status_q;
      `MMP_OFS_LOCK:    rd_d[7:0] = lock_w;
      `MMP_OFS_FUSE: begin
        rd_d[7:0] = fuse_w;
        err_d     = pwrite;
      end
      `MMP_OFS_INDEX:   rd_d[4:0] = index_q;
      `MMP_OFS_SIGDATA: begin
        rd_d[7:0] = sig_byte(index_q);
        err_d     = pwrite;
      end
      `MMP_OFS_USIGCMD: rd_d = 32'h00000000;
      `MMP_OFS_EEBUF:   rd_d[7:0] = ee_buf[index_q];
      default:          err_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel && !penable && err_d;
      if (psel && !penable && !pwrite)
        prdata <= rd_d;
    end
  end

endmodule

//--- bench/mmp_top_properties.sv
// Concurrent checks on the memory map and nonvolatile access block
`timescale 1ns/100ps
`include "mmp_regs.vh"

module mmp_chk #(
  parameter [7:0] CAL_OSC = 8'h40,
  parameter [7:0] CAL_ADC = 8'h20
) (
  // Clock and reset
  input logic        pclk,
  input logic        presetn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic        pslverr,
  // CPU data access
  input logic        cpu_req,
  input logic        cpu_we,
  input logic [15:0] cpu_addr,
  input logic        sel_io_q,
  input logic        sel_ee_q,
  input logic        sel_sram_q,
  input logic        sel_rsvd_q,
  input logic        cpu_done_q,
  input logic [4:0]  eeprom_byte_index_q,
  // Self-write and programmer
  input logic        spm_req,
  input logic [16:0] spm_pc,
  input logic [16:0] spm_addr,
  input logic        flash_wr_q,
  input logic [16:0] flash_addr_q,
  input logic        prog_valid,
  input logic [1:0]  prog_op,
  input logic        flash_erase_q,
  // Calibration
  input logic [7:0]  cal_osc_q,
  input logic [7:0]  cal_adc_q,
  input logic        cal_done_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Request windows as nets for $past
  wire       in_sram = cpu_addr[15:13] == 3'b001;
  wire       in_ee   = cpu_addr[15:11] == 5'b00010;
  wire [4:0] ee_lo   = cpu_addr[4:0];

  a_io_one_cycle: assert property (cpu_req && cpu_addr <= `MMP_IO_END
    |=> sel_io_q && cpu_done_q) else $error("io not one cycle");
  a_sram_rd_two: assert property (cpu_req && !cpu_we && in_sram
    |=> sel_sram_q && !cpu_done_q ##1 cpu_done_q) else $error("sram read not two cycles");
  a_sram_wr_one: assert property (cpu_req && cpu_we && in_sram
    |=> sel_sram_q && cpu_done_q) else $error("sram write not one cycle");
  a_gap_reserved: assert property (cpu_req && cpu_addr[15:11] == 5'b00011
    |=> sel_rsvd_q && !sel_ee_q) else $error("gap not reserved");
  a_ee_byte_index: assert property (sel_ee_q
    |-> $past(in_ee) && eeprom_byte_index_q == $past(ee_lo)) else $error("bad byte index");
  a_spm_app_none: assert property (spm_req && spm_pc < `MMP_BOOT_BASE
    |=> !flash_wr_q) else $error("grant outside boot");
  a_spm_grant_src: assert property (flash_wr_q |-> $past(spm_req)
    && $past(spm_pc) >= `MMP_BOOT_BASE && flash_addr_q == $past(spm_addr))
    else $error("grant without boot request");
  a_erase_strobe: assert property (prog_valid && prog_op == `MMP_POP_CHIPER
    |-> ##2 flash_erase_q) else $error("no erase strobe");
  a_fuse_wr_err: assert property (psel && !penable && pwrite
    && paddr == `MMP_OFS_FUSE |=> pslverr) else $error("fuse write not refused");
  a_sig_wr_err: assert property (psel && !penable && pwrite
    && paddr == `MMP_OFS_SIGDATA |=> pslverr) else $error("sig write not refused");
  a_cal_loaded: assert property ($rose(cal_done_q)
    |-> cal_osc_q == CAL_OSC && cal_adc_q == CAL_ADC) else $error("cal not loaded");
endmodule

bind mmp_top mmp_chk #(.CAL_OSC(CAL_OSC), .CAL_ADC(CAL_ADC)) u_mmp_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pslverr(pslverr), .cpu_req(cpu_req), .cpu_we(cpu_we),
  .cpu_addr(cpu_addr), .sel_io_q(sel_io_q), .sel_ee_q(sel_ee_q), .sel_sram_q(sel_sram_q),
  .sel_rsvd_q(sel_rsvd_q), .cpu_done_q(cpu_done_q),
  .eeprom_byte_index_q(eeprom_byte_index_q), .spm_req(spm_req), .spm_pc(spm_pc),
  .spm_addr(spm_addr), .flash_wr_q(flash_wr_q), .flash_addr_q(flash_addr_q),
  .prog_valid(prog_valid), .prog_op(prog_op), .flash_erase_q(flash_erase_q),
  .cal_osc_q(cal_osc_q), .cal_adc_q(cal_adc_q), .cal_done_q(cal_done_q));

//--- bench/mmp_far_side.sv
// Model of the CPU core and external programmer facing the block
`timescale 1ns/100ps

module mmp_far_side (
  // Clock
  input  logic        pclk,
  // CPU data access, sel is {io, ee, sram, reserved}
  output logic        cpu_req,
  output logic        cpu_we,
  output logic [15:0] cpu_addr,
  output logic [7:0]  cpu_wdata,
  input  logic [3:0]  cpu_sel,
  input  logic        cpu_done,
  // Flash self-write
  output logic        spm_req,
  output logic [16:0] spm_pc,
  output logic [16:0] spm_addr,
  output logic [15:0] spm_wdata,
  input  logic        flash_wr,
  // Programmer
  output logic        prog_valid,
  output logic [1:0]  prog_op,
  output logic [7:0]  prog_data
);
  // Idle at time zero
  initial begin
    {cpu_req, cpu_we, cpu_addr, cpu_wdata} = '0;
    {spm_req, spm_pc, spm_addr, spm_wdata} = '0;
    {prog_valid, prog_op, prog_data} = '0;
  end

  // CPU access; released lines flip
  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [3:0] s, output logic [1:0] lat);
    @(posedge pclk);
    cpu_req <= 1'b1;
    cpu_we <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge pclk);
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
    #1;
    s = cpu_sel;
    lat = 2'd1;
    if (cpu_done !== 1'b1) begin
      @(posedge pclk);
      #1;
      lat = (cpu_done === 1'b1) ? 2'd2 : 2'd3;
    end
  endtask

  // Self-write; g is the grant
  task automatic flash_self_write_instruction(input logic [16:0] pc, input logic [16:0] a, input logic [15:0] d,
                     output logic g);
    @(posedge pclk);
    spm_req <= 1'b1;
    spm_pc <= pc;
    spm_addr <= a;
    spm_wdata <= d;
    @(posedge pclk);
    spm_req <= 1'b0;
    spm_addr <= ~a;
    spm_wdata <= ~d;
    #1;
    g = flash_wr;
  endtask

  // One programmer operation
  task automatic prog(input logic [1:0] op, input logic [7:0] d);
    @(posedge pclk);
    prog_valid <= 1'b1;
    prog_op <= op;
    prog_data <= d;
    @(posedge pclk);
    prog_valid <= 1'b0;
    prog_data <= ~d;
  endtask
endmodule

//--- bench/tb_mmp_top.sv
// Self-checking bench for the memory map and nonvolatile access block
`timescale 1ns/100ps
`include "mmp_regs.vh"

module tb_mmp_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, cpu_req, cpu_we, sel_io_q, sel_ee_q, sel_sram_q;
  logic        sel_rsvd_q, cpu_done_q, spm_req, flash_wr_q, prog_valid;
  logic        flash_erase_q, usig_erase_q, cal_done_q, g;
  logic [15:0] cpu_addr, spm_wdata, flash_wdata_q;
  logic [7:0]  cpu_wdata, prog_data, cal_osc_q, cal_adc_q;
  logic [5:0]  eeprom_page_index_q;
  logic [4:0]  eeprom_byte_index_q;
  logic [16:0] spm_pc, spm_addr, flash_addr_q;
  logic [1:0]  prog_op, lat;
  logic [3:0]  s;
  int          n_fail = 0, checks = 0, cyc = 0, n_usig = 0, n_er = 0;
  // Signature row contents
  logic [7:0]  sig [9] = '{8'hA5, 8'h5A, 8'h3C, 8'h11, 8'h02, 8'h03, 8'h04, 8'h40, 8'h20};

  always #2.5 pclk = ~pclk;

  mmp_top u_mmp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .sel_io_q(sel_io_q), .sel_ee_q(sel_ee_q),
    .sel_sram_q(sel_sram_q), .sel_rsvd_q(sel_rsvd_q), .cpu_done_q(cpu_done_q),
    .eeprom_page_index_q(eeprom_page_index_q), .eeprom_byte_index_q(eeprom_byte_index_q),
    .spm_req(spm_req), .spm_pc(spm_pc), .spm_addr(spm_addr), .spm_wdata(spm_wdata),
    .flash_wr_q(flash_wr_q), .flash_addr_q(flash_addr_q), .flash_wdata_q(flash_wdata_q),
    .prog_valid(prog_valid), .prog_op(prog_op), .prog_data(prog_data),
    .flash_erase_q(flash_erase_q), .usig_erase_q(usig_erase_q), .cal_osc_q(cal_osc_q),
    .cal_adc_q(cal_adc_q), .cal_done_q(cal_done_q));

  mmp_far_side u_mmp_far_side (.pclk(pclk), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_sel({sel_io_q, sel_ee_q, sel_sram_q, sel_rsvd_q}), .cpu_done(cpu_done_q),
    .spm_req(spm_req), .spm_pc(spm_pc), .spm_addr(spm_addr), .spm_wdata(spm_wdata),
    .flash_wr(flash_wr_q), .prog_valid(prog_valid), .prog_op(prog_op),
    .prog_data(prog_data));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    checks++;
    if (v !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // APB transfer, sampled at the pready edge
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] ed, input logic ee);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    if (!w) chk("rd", ed, prdata);
    chk("err", 32'(ee), 32'(pslverr));
  endtask

  task automatic cp(input logic w, input logic [15:0] a, input logic [3:0] es,
                    input logic [1:0] el);
    u_mmp_far_side.cpu(w, a, 8'h5C, s, lat);
    chk("sel", 32'(es), 32'(s));
    chk("lat", 32'(el), 32'(lat));
  endtask

  task automatic sp(input logic [16:0] pc, input logic [16:0] a, input logic eg);
    u_mmp_far_side.flash_self_write_instruction(pc, a, 16'hBEEF, g);
    chk("grant", 32'(eg), 32'(g));
  endtask

  // Strobe counters and hang limit
  always @(posedge pclk) begin
    cyc++;
    if (usig_erase_q === 1'b1) n_usig++;
    if (flash_erase_q === 1'b1) n_er++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    // Reset values, identity and calibration
    xf(0, `MMP_OFS_LOCK, 0, 32'hFF, 0);
    xf(0, `MMP_OFS_FUSE, 0, 32'hFF, 0);
    xf(0, `MMP_OFS_STATUS, 0, 32'h20, 0);
    xf(0, 8'h40, 0, 32'h0, 1);
    for (int i = 0; i < 9; i++) begin
      xf(1, `MMP_OFS_INDEX, i, 0, 0);
      xf(0, `MMP_OFS_SIGDATA, 0, 32'(sig[i]), 0);
    end
    // Refused writes leave contents alone
    xf(1, `MMP_OFS_FUSE, 32'h0, 0, 1);
    xf(1, `MMP_OFS_SIGDATA, 32'h0, 0, 1);
    xf(0, `MMP_OFS_FUSE, 0, 32'hFF, 0);
    xf(0, `MMP_OFS_SIGDATA, 0, 32'(sig[8]), 0);
    xf(0, `MMP_OFS_STATUS, 0, 32'h2C, 0);
    xf(1, `MMP_OFS_STATUS, 32'hFF, 0, 0);
    // Locks only tighten
    xf(1, `MMP_OFS_LOCK, 32'hFC, 0, 0);
    xf(1, `MMP_OFS_LOCK, 32'hFF, 0, 0);
    xf(0, `MMP_OFS_LOCK, 0, 32'hFC, 0);
    xf(0, `MMP_OFS_STATUS, 0, 32'h22, 0);
    xf(1, `MMP_OFS_STATUS, 32'hFF, 0, 0);
    // Self-write from boot only
    sp(17'h00100, 17'h10020, 0);
    sp(17'h0FFFF, 17'h10020, 0);
    sp(17'h10010, 17'h10020, 1);
    chk("faddr", 32'h10020, 32'(flash_addr_q));
    chk("fdata", 32'hBEEF, 32'(flash_wdata_q));
    sp(17'h10FFF, 17'h0F000, 1);
    sp(17'h10010, 17'h0EFFF, 0);
    chk("faddr", 32'h0F000, 32'(flash_addr_q));
    xf(0, `MMP_OFS_STATUS, 0, 32'h21, 0);
    xf(1, `MMP_OFS_STATUS, 32'hFF, 0, 0);
    // Data space decode with mapping off, then on
    cp(0, 16'h0FFF, 4'h8, 1);
    cp(0, 16'h1000, 4'h1, 1);
    cp(1, 16'h1FFF, 4'h1, 1);
    cp(0, 16'h2000, 4'h2, 2);
    cp(1, 16'h3FFF, 4'h2, 1);
    cp(0, 16'h4000, 4'h1, 1);
    xf(1, `MMP_OFS_CTRL, 32'h1, 0, 0);
    cp(1, 16'h17E5, 4'h4, 1);
    chk("page", 32'h3F, 32'(eeprom_page_index_q));
    chk("byte", 32'h05, 32'(eeprom_byte_index_q));
    cp(0, 16'h1800, 4'h1, 1);
    xf(1, `MMP_OFS_INDEX, 5, 0, 0);
    xf(0, `MMP_OFS_EEBUF, 0, 32'h5C, 0);
    // User row erase, programmer writes
    xf(1, `MMP_OFS_USIGCMD, 32'h1, 0, 0);
    repeat (2) @(posedge pclk);
    chk("usig", 1, n_usig);
    u_mmp_far_side.prog(`MMP_POP_FUSE, 8'hF0);
    u_mmp_far_side.prog(`MMP_POP_LOCK, 8'hFF);
    xf(0, `MMP_OFS_FUSE, 0, 32'hF0, 0);
    u_mmp_far_side.prog(`MMP_POP_LOCK, 8'hF0);
    xf(0, `MMP_OFS_LOCK, 0, 32'hF0, 0);
    // Chip erase: locks hold until the end, user row spared
    u_mmp_far_side.prog(`MMP_POP_CHIPER, 8'h00);
    xf(0, `MMP_OFS_LOCK, 0, 32'hF0, 0);
    xf(0, `MMP_OFS_STATUS, 0, 32'h32, 0);
    repeat (20) @(posedge pclk);
    xf(0, `MMP_OFS_LOCK, 0, 32'hFF, 0);
    chk("erase", 1, n_er);
    chk("usig", 1, n_usig);
    print_verdict;
  end
endmodule
